// file: design/bsu_pkg.sv
// Constants for the serial bootloader update block.
// Assumes a 100 MHz clock and an external UART byte engine.

package bsu_pkg;

  // ********************
  // Timing
  // ********************
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned TIMEOUT_S = 60;
  localparam longint unsigned GAP_MS = 1000;
  localparam logic [39:0] TIMEOUT_CYC = 40'(TIMEOUT_S * CLK_HZ);
  localparam logic [39:0] GAP_CYC = 40'(GAP_MS * (CLK_HZ / 1000));

  // ********************
  // Characters
  // ********************
  localparam logic [7:0] CHR_CR = 8'h0d;
  localparam logic [7:0] CHR_ONE = 8'h31;
  localparam logic [7:0] CHR_C = 8'h43;
  localparam logic [7:0] CHR_SOH = 8'h01;
  localparam logic [7:0] CHR_EOT = 8'h04;
  localparam logic [7:0] CHR_ACK = 8'h06;

  // ********************
  // Error codes
  // ********************
  localparam logic [7:0] ERR_SOH = 8'h21;
  localparam logic [7:0] ERR_CHK = 8'h22;
  localparam logic [7:0] ERR_CRC_HI = 8'h23;
  localparam logic [7:0] ERR_CRC_LO = 8'h24;
  localparam logic [7:0] ERR_SEQ = 8'h25;
  localparam logic [7:0] ERR_INCOMPLETE = 8'h26;
  localparam logic [7:0] ERR_DUP = 8'h27;
  localparam logic [7:0] IMG_ERR_FIRST = 8'h41;
  localparam logic [7:0] IMG_ERR_LAST = 8'h45;
  localparam logic [7:0] PROG_ERR_FIRST = 8'h46;
  localparam logic [7:0] PROG_ERR_LAST = 8'h4d;

  // ********************
  // Frame layout and resets
  // ********************
  localparam logic [7:0] POS_SEQ = 8'd1;
  localparam logic [7:0] POS_NSEQ = 8'd2;
  localparam logic [7:0] POS_DATA0 = 8'd3;
  localparam logic [7:0] POS_DATA_LAST = 8'd130;
  localparam logic [7:0] POS_CRC_HI = 8'd131;
  localparam logic [7:0] POS_CRC_LO = 8'd132;
  localparam logic [7:0] SEQ_FIRST = 8'h01;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [3:0] MENU_LAST = 4'hf;

  typedef enum logic [6:0] {
    ST_APP = 7'b0000001,
    ST_BREAK = 7'b0000010,
    ST_WAIT_CR = 7'b0000100,
    ST_MENU = 7'b0001000,
    ST_CMD = 7'b0010000,
    ST_XWAIT = 7'b0100000,
    ST_XFER = 7'b1000000
  } bsu_state_t;

endpackage : bsu_pkg

// file: design/bsu_tx_buf.sv
// Two-entry byte buffer between the bootloader and the UART transmitter.
// Assumes the consumer may hold out_ready low for any time.
`timescale 1ns/10ps
`default_nettype none

module bsu_tx_buf #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);

  logic [W-1:0] d1_q;
  logic v1_q;
  logic push;
  logic pop;

  assign push = in_valid && !v1_q;
  assign pop = out_valid && out_ready;
  // Ready only from the second slot, so it is a flop and never combinational
  assign in_ready = !v1_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      v1_q <= 1'b0;
      out_data <= '0;
      d1_q <= '0;
    end else if (ce) begin
      if (pop) begin
        if (v1_q) begin
          out_data <= d1_q;
          v1_q <= push;
          d1_q <= in_data;
        end else begin
          out_valid <= push;
          out_data <= in_data;
        end
      end else if (push) begin
        if (!out_valid) begin
          out_valid <= 1'b1;
          out_data <= in_data;
        end else begin
          v1_q <= 1'b1;
          d1_q <= in_data;
        end
      end
    end
  end

endmodule : bsu_tx_buf
`default_nettype wire

// file: design/bsu_loader.sv
// Serial bootloader: pin-strapped entry, menu, XModem-CRC receive, error codes.
// Assumes an external UART delivers received bytes and drains tx bytes.
`timescale 1ns/10ps
`default_nettype none

module bsu_loader #(
  parameter logic [39:0] TIMEOUT_CYC = bsu_pkg::TIMEOUT_CYC,
  parameter logic [39:0] GAP_CYC = bsu_pkg::GAP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Entry pins
  input wire logic din,
  input wire logic sleep_request_line,
  input wire logic rts,
  input wire logic image_valid,
  // Received bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  // Transmit bytes
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  // Image writer
  output logic [7:0] img_byte_q,
  output logic img_valid_q,
  output logic img_done_q,
  input wire logic img_err_valid,
  input wire logic [7:0] img_err_code,
  // Status
  output logic bl_active_q,
  output logic baud_9600_q,
  output logic settings_lock_q
);

  bsu_pkg::bsu_state_t state_q;
  logic strap_done_q;
  logic pend_q;
  logic [7:0] pend_byte_q;
  logic buf_ready;
  logic [39:0] timer_q;
  logic [7:0] pos_q;
  logic [7:0] seq_q;
  logic [7:0] exp_seq_q;
  logic [15:0] crc_q;
  logic [3:0] menu_idx_q;
  logic [7:0] err_d;
  logic in_xfer;
  logic ext_err;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ bsu_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_step

  function automatic logic [7:0] menu_char(input logic [3:0] i);
    unique case (i)
      4'h0: menu_char = 8'h0d;
      4'h1: menu_char = 8'h0a;
      4'h2: menu_char = 8'h31;
      4'h3: menu_char = 8'h2e;
      4'h4: menu_char = 8'h75;
      4'h5: menu_char = 8'h70;
      4'h6: menu_char = 8'h6c;
      4'h7: menu_char = 8'h6f;
      4'h8: menu_char = 8'h61;
      4'h9: menu_char = 8'h64;
      4'ha: menu_char = 8'h0d;
      4'hb: menu_char = 8'h0a;
      4'hc: menu_char = 8'h42;
      4'hd: menu_char = 8'h4c;
      4'he: menu_char = 8'h20;
      4'hf: menu_char = 8'h3e;
    endcase
  endfunction : menu_char

  // ********************
  // Transmit path
  // ********************
  bsu_tx_buf #(.W(8)) u_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(pend_q),
    .in_data(pend_byte_q),
    .in_ready(buf_ready),
    .out_valid(tx_valid),
    .out_data(tx_byte),
    .out_ready(tx_ready)
  );

  // ********************
  // Reset strap
  // ********************
  // Sampled one clock after release, never under reset itself
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strap_done_q <= 1'b0;
      baud_9600_q <= 1'b0;
    end else if (ce && !strap_done_q) begin
      strap_done_q <= 1'b1;
      baud_9600_q <= !din;
    end
  end

  // ********************
  // Frame checker
  // ********************
  assign in_xfer = (state_q == bsu_pkg::ST_XWAIT) || (state_q == bsu_pkg::ST_XFER);
  assign ext_err = img_err_valid && (img_err_code >= bsu_pkg::IMG_ERR_FIRST)
                   && (img_err_code <= bsu_pkg::PROG_ERR_LAST);

  always_comb begin
    err_d = 8'h00;
    if (pos_q == 8'd0) begin
      if (rx_byte != bsu_pkg::CHR_SOH && rx_byte != bsu_pkg::CHR_EOT) begin
        err_d = bsu_pkg::ERR_SOH;
      end
    end else if (pos_q == bsu_pkg::POS_NSEQ) begin
      if (rx_byte != ~seq_q) begin
        err_d = bsu_pkg::ERR_CHK;
      end else if (seq_q == exp_seq_q - 8'd1) begin
        err_d = bsu_pkg::ERR_DUP;
      end else if (seq_q != exp_seq_q) begin
        err_d = bsu_pkg::ERR_SEQ;
      end
    end else if (pos_q == bsu_pkg::POS_CRC_HI) begin
      if (rx_byte != crc_q[15:8]) begin
        err_d = bsu_pkg::ERR_CRC_HI;
      end
    end else if (pos_q == bsu_pkg::POS_CRC_LO) begin
      if (rx_byte != crc_q[7:0]) begin
        err_d = bsu_pkg::ERR_CRC_LO;
      end
    end
  end

  // ********************
  // Control sequence
  // ********************
  // Bytes arriving while a reply waits are dropped; the host waits for replies
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= bsu_pkg::ST_APP;
      pend_q <= 1'b0;
      pend_byte_q <= 8'h00;
      timer_q <= '0;
      pos_q <= 8'd0;
      seq_q <= 8'h00;
      exp_seq_q <= bsu_pkg::SEQ_FIRST;
      crc_q <= bsu_pkg::CRC_INIT;
      menu_idx_q <= 4'h0;
      img_byte_q <= 8'h00;
      img_valid_q <= 1'b0;
      img_done_q <= 1'b0;
    end else if (ce) begin
      img_valid_q <= 1'b0;
      img_done_q <= 1'b0;
      if (pend_q && buf_ready) begin
        pend_q <= 1'b0;
      end
      if (timer_q != '0) begin
        timer_q <= timer_q - 40'd1;
      end
      if (!strap_done_q) begin
        menu_idx_q <= 4'h0;
        if (!din && !sleep_request_line && rts) begin
          state_q <= bsu_pkg::ST_BREAK;
        end else if (!image_valid) begin
          state_q <= bsu_pkg::ST_MENU;
        end
      end else if (!pend_q) begin
        unique case (state_q)
          bsu_pkg::ST_APP: begin
          end
          bsu_pkg::ST_BREAK: begin
            if (din) begin
              state_q <= bsu_pkg::ST_WAIT_CR;
            end
          end
          bsu_pkg::ST_WAIT_CR: begin
            if (rx_valid && rx_byte == bsu_pkg::CHR_CR) begin
              state_q <= bsu_pkg::ST_MENU;
            end
          end
          bsu_pkg::ST_MENU: begin
            pend_q <= 1'b1;
            pend_byte_q <= menu_char(menu_idx_q);
            menu_idx_q <= menu_idx_q + 4'h1;
            if (menu_idx_q == bsu_pkg::MENU_LAST) begin
              state_q <= bsu_pkg::ST_CMD;
            end
          end
          bsu_pkg::ST_CMD: begin
            if (rx_valid && rx_byte == bsu_pkg::CHR_ONE) begin
              state_q <= bsu_pkg::ST_XWAIT;
              pend_q <= 1'b1;
              pend_byte_q <= bsu_pkg::CHR_C;
              timer_q <= TIMEOUT_CYC;
              pos_q <= 8'd0;
              exp_seq_q <= bsu_pkg::SEQ_FIRST;
            end else if (rx_valid && rx_byte == bsu_pkg::CHR_CR) begin
              state_q <= bsu_pkg::ST_MENU;
            end
          end
          bsu_pkg::ST_XWAIT, bsu_pkg::ST_XFER: begin
            if (ext_err) begin
              pend_q <= 1'b1;
              pend_byte_q <= img_err_code;
              state_q <= bsu_pkg::ST_CMD;
              pos_q <= 8'd0;
            end else if (rx_valid && err_d != 8'h00) begin
              pend_q <= 1'b1;
              pend_byte_q <= err_d;
              state_q <= bsu_pkg::ST_CMD;
              pos_q <= 8'd0;
            end else if (rx_valid) begin
              state_q <= bsu_pkg::ST_XFER;
              timer_q <= GAP_CYC;
              if (pos_q == 8'd0 && rx_byte == bsu_pkg::CHR_EOT) begin
                pend_q <= 1'b1;
                pend_byte_q <= bsu_pkg::CHR_ACK;
                img_done_q <= 1'b1;
                state_q <= bsu_pkg::ST_MENU;
              end else if (pos_q == bsu_pkg::POS_CRC_LO) begin
                pend_q <= 1'b1;
                pend_byte_q <= bsu_pkg::CHR_ACK;
                exp_seq_q <= exp_seq_q + 8'd1;
                pos_q <= 8'd0;
                timer_q <= TIMEOUT_CYC;
              end else begin
                pos_q <= pos_q + 8'd1;
              end
              if (pos_q == bsu_pkg::POS_SEQ) begin
                seq_q <= rx_byte;
                crc_q <= bsu_pkg::CRC_INIT;
              end
              if (pos_q >= bsu_pkg::POS_DATA0 && pos_q <= bsu_pkg::POS_DATA_LAST) begin
                crc_q <= crc_step(crc_q, rx_byte);
                img_byte_q <= rx_byte;
                img_valid_q <= 1'b1;
              end
            end else if (timer_q == '0) begin
              pos_q <= 8'd0;
              if (pos_q != 8'd0) begin
                pend_q <= 1'b1;
                pend_byte_q <= bsu_pkg::ERR_INCOMPLETE;
                state_q <= bsu_pkg::ST_CMD;
              end else begin
                state_q <= bsu_pkg::ST_MENU;
              end
            end
          end
        endcase
      end
    end
  end

  // ********************
  // Status
  // ********************
  // Settings area stays write-locked while the loader owns flash
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bl_active_q <= 1'b0;
      settings_lock_q <= 1'b1;
    end else if (ce) begin
      bl_active_q <= (state_q != bsu_pkg::ST_APP);
      settings_lock_q <= (state_q != bsu_pkg::ST_APP);
    end
  end

  // ********************
  // Checks
  // ********************
  menu_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce && !pend_q && state_q == bsu_pkg::ST_WAIT_CR && rx_valid && rx_byte == bsu_pkg::CHR_CR
    |=> state_q == bsu_pkg::ST_MENU ##1 (!$past(ce) || (pend_q && pend_byte_q == 8'h0d)))
    else $error("menu not started after carriage return");

  update_select_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce && !pend_q && state_q == bsu_pkg::ST_CMD && rx_valid && rx_byte == bsu_pkg::CHR_ONE
    |=> state_q == bsu_pkg::ST_XWAIT && pend_q && pend_byte_q == bsu_pkg::CHR_C
        && timer_q == TIMEOUT_CYC)
    else $error("update selection not taken");

  wait_timeout_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce && !pend_q && state_q == bsu_pkg::ST_XWAIT && timer_q == '0 && !rx_valid && !ext_err
    |=> state_q == bsu_pkg::ST_MENU)
    else $error("upload wait did not time out to menu");

  bad_image_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce && !strap_done_q && !image_valid |=> ##1 (bl_active_q || !$past(ce)))
    else $error("invalid image did not start loader");

  soh_error_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce && !pend_q && in_xfer && !ext_err && rx_valid && pos_q == 8'd0
    && rx_byte != bsu_pkg::CHR_SOH && rx_byte != bsu_pkg::CHR_EOT
    |=> pend_q && pend_byte_q == bsu_pkg::ERR_SOH && state_q == bsu_pkg::ST_CMD)
    else $error("bad frame start not reported");

  forward_error_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce && !pend_q && in_xfer && ext_err |=> pend_q && pend_byte_q == $past(img_err_code))
    else $error("image error code not forwarded");

  settings_lock_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce && state_q != bsu_pkg::ST_APP ##1 ce |=> settings_lock_q)
    else $error("settings unlocked during load");

  slow_baud_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce && !strap_done_q && !din |=> baud_9600_q [*4])
    else $error("break at reset did not force slow rate");

  stay_loader_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(pend_q) && pend_byte_q >= bsu_pkg::ERR_SOH && pend_byte_q <= bsu_pkg::ERR_DUP
    |-> state_q == bsu_pkg::ST_CMD ##1 bl_active_q || !ce)
    else $error("loader left after error code");

endmodule : bsu_loader
`default_nettype wire

// file: test/bsu_host.sv
// Host model for the bootloader: strap pins, byte sender, stalling drain.
// Assumes the UART bit engine is abstracted into byte strobes.
`timescale 1ns/10ps
`default_nettype none

module bsu_host (
  // Clock
  input wire logic clk,
  input wire logic ce,
  // Transmit drain
  output logic tx_ready,
  // Pins and received bytes
  output logic din,
  output logic sleep_request_line,
  output logic rts,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  bit slow = 1'b0;

  initial begin
    din = 1'b1;
    sleep_request_line = 1'b1;
    rts = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end

  // No handshake gating; a slow host stalls at random instead
  always @(negedge clk) begin
    tx_ready <= slow ? ($urandom_range(3) == 0) : 1'b1;
  end

  // ********************
  // Entry straps
  // ********************
  task automatic strap(input bit entry);
    sleep_request_line = !entry;
    rts = entry;
    din = !entry;
  endtask : strap

  task automatic send(input logic [7:0] b);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_byte = b;
    // A byte only lands on an enabled edge, so hold it until one passes
    do @(posedge clk); while (ce !== 1'b1);
    @(negedge clk);
    rx_valid = 1'b0;
    rx_byte = ~b; // Stale data must never look like the last byte
  endtask : send

  // Break ends first, carriage return after
  task automatic end_break;
    @(negedge clk);
    din = 1'b1;
    send(8'h0d);
  endtask : end_break

  // Defaults back, settings set, then saved; the running application owns
  // this traffic, so the loader must stay silent
  task automatic reconfigure;
    send(8'h0d);
    send(8'h31);
    send(8'h0d);
  endtask : reconfigure

endmodule : bsu_host
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the serial bootloader block.
// Assumes bsu_pkg, the design and the host model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic clk, sys_rst, ce, image_valid, din, sleep_request_line, rts;
  logic rx_valid, tx_valid, tx_ready, img_valid_q, img_done_q, img_err_valid;
  logic bl_active_q, baud_9600_q, settings_lock_q;
  logic [7:0] rx_byte, tx_byte, img_byte_q, img_err_code;
  int fails = 0;
  int checked = 0;
  int img_cnt = 0;
  int done_cnt = 0;
  int n;
  time t0;
  bit ce_rand = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] menu[16] = '{8'h0d, 8'h0a, 8'h31, 8'h2e, 8'h75, 8'h70, 8'h6c, 8'h6f,
                           8'h61, 8'h64, 8'h0d, 8'h0a, 8'h42, 8'h4c, 8'h20, 8'h3e};
  logic [31:0] errs[4] = '{32'h55000021, 32'h01010022, 32'h01807f25, 32'h01000026};

  // Short counts keep the run brief
  bsu_loader #(.TIMEOUT_CYC(40'd2000), .GAP_CYC(40'd500)) u_bsu_loader (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .din(din),
    .sleep_request_line(sleep_request_line), .rts(rts), .image_valid(image_valid),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready), .img_byte_q(img_byte_q), .img_valid_q(img_valid_q),
    .img_done_q(img_done_q), .img_err_valid(img_err_valid), .img_err_code(img_err_code),
    .bl_active_q(bl_active_q), .baud_9600_q(baud_9600_q), .settings_lock_q(settings_lock_q));

  bsu_host u_bsu_host (
    .clk(clk), .ce(ce), .tx_ready(tx_ready), .din(din),
    .sleep_request_line(sleep_request_line),
    .rts(rts), .rx_valid(rx_valid), .rx_byte(rx_byte));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Random enable gaps; off where strap timing or cycle counts are measured
  always @(negedge clk) begin
    ce <= ce_rand ? ($urandom_range(3) != 0) : 1'b1;
  end

  // ********************
  // Compare and report
  // ********************
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t byte %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t flag %s is %b", $time, what, got);
    end
  endtask : cmp_bit

  task automatic cmp_cnt(input int got, input int exp, input string what);
    checked++;
    if (got != exp) begin
      fails++;
      $display("mismatch t=%0t count %s %0d expected %0d", $time, what, got, exp);
    end
  endtask : cmp_cnt

  task automatic test_done;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    if (!sys_rst && ce && tx_valid === 1'b1 && tx_ready) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("mismatch t=%0t unexpected byte %h", $time, tx_byte);
      end else begin
        cmp_byte(tx_byte, exp_q.pop_front());
      end
    end
    // Pulses stretch while the enable is low; count each once
    if (ce && img_valid_q === 1'b1) img_cnt++;
    if (ce && img_done_q === 1'b1) done_cnt++;
  end

  // ********************
  // Host sequences
  // ********************
  task automatic wait_idle;
    int k = 0;
    while (exp_q.size() != 0 && k < 5000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 5000) begin
      fails++;
      exp_q.delete();
      $display("mismatch t=%0t reply never came", $time);
    end
    repeat (6) @(negedge clk);
  endtask : wait_idle

  task automatic push_menu;
    foreach (menu[i]) exp_q.push_back(menu[i]);
  endtask : push_menu

  task automatic start_up;
    exp_q.push_back(8'h43);
    u_bsu_host.send(8'h31);
    wait_idle();
  endtask : start_up

  // Mode 0 good, 1 bad crc high (frame cut there), 2 bad crc low
  task automatic xfer(input logic [7:0] seq, input int mode, input logic [7:0] exp);
    logic [7:0] d;
    logic [15:0] crc = 16'h0000;
    exp_q.push_back(exp);
    u_bsu_host.send(8'h01);
    u_bsu_host.send(seq);
    u_bsu_host.send(~seq);
    repeat (128) begin
      d = 8'($urandom);
      crc = crc ^ {d, 8'h00};
      repeat (8) crc = crc[15] ? ((crc << 1) ^ 16'h1021) : (crc << 1);
      u_bsu_host.send(d);
    end
    u_bsu_host.send(crc[15:8] ^ ((mode == 1) ? 8'h01 : 8'h00));
    if (mode != 1) u_bsu_host.send(crc[7:0] ^ ((mode == 2) ? 8'h01 : 8'h00));
    wait_idle();
  endtask : xfer

  // Truncated header; trailing bytes stay off the command characters
  task automatic hdr(input logic [31:0] t);
    exp_q.push_back(t[7:0]);
    u_bsu_host.send(t[31:24]);
    if (t[23:16] != 8'h00) begin
      u_bsu_host.send(t[23:16]);
      u_bsu_host.send(t[15:8]);
    end
    wait_idle();
  endtask : hdr

  task automatic do_reset(input bit entry, input logic iv);
    @(negedge clk);
    sys_rst = 1'b1;
    u_bsu_host.strap(entry);
    image_valid = iv;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    // Sampled once after release; later changes must not matter
    image_valid = 1'($urandom);
    repeat (2) @(negedge clk);
  endtask : do_reset

  initial begin
    sys_rst = 1'b1;
    image_valid = 1'b1;
    img_err_valid = 1'b0;
    img_err_code = 8'h00;
    void'($urandom(25747));
    do_reset(1'b1, 1'b1);
    cmp_bit(baud_9600_q, 1'b1, "baud");
    cmp_bit(bl_active_q, 1'b1, "active");
    cmp_bit(settings_lock_q, 1'b1, "lock");
    u_bsu_host.send(8'h31);
    repeat (10) @(negedge clk);
    u_bsu_host.slow = 1'b1;
    push_menu();
    u_bsu_host.end_break();
    wait_idle();
    ce_rand = 1'b1;
    start_up();
    xfer(8'h01, 1, 8'h23);
    start_up();
    xfer(8'h01, 2, 8'h24);
    start_up();
    n = img_cnt;
    xfer(8'h01, 0, 8'h06);
    xfer(8'h02, 0, 8'h06);
    cmp_cnt(img_cnt - n, 256, "payload");
    hdr(32'h0102fd27);
    foreach (errs[i]) begin
      start_up();
      hdr(errs[i]);
    end
    for (int c = 'h41; c <= 'h4d; c++) begin
      start_up();
      exp_q.push_back(8'(c));
      @(negedge clk);
      img_err_valid = 1'b1;
      img_err_code = 8'(c);
      do @(posedge clk); while (ce !== 1'b1);
      @(negedge clk);
      img_err_valid = 1'b0;
      img_err_code = 8'($urandom);
      wait_idle();
    end
    cmp_bit(bl_active_q, 1'b1, "stay");
    start_up();
    exp_q.push_back(8'h06);
    push_menu();
    n = done_cnt;
    u_bsu_host.send(8'h04);
    wait_idle();
    cmp_cnt(done_cnt - n, 1, "done");
    ce_rand = 1'b0;
    exp_q.push_back(8'h43);
    push_menu();
    t0 = $time;
    u_bsu_host.send(8'h31);
    wait_idle();
    n = int'(($time - t0) / 10);
    cmp_bit(n >= 2000 && n <= 2300, 1'b1, "timeout");
    // Invalid image without straps lands straight in the menu
    push_menu();
    do_reset(1'b0, 1'b0);
    wait_idle();
    cmp_bit(baud_9600_q, 1'b0, "baud");
    start_up();
    xfer(8'h01, 0, 8'h06);
    do_reset(1'b0, 1'b1);
    cmp_bit(bl_active_q, 1'b0, "app");
    cmp_bit(settings_lock_q, 1'b0, "unlock");
    u_bsu_host.reconfigure();
    wait_idle();
    test_done();
  end

  // Run needs roughly 5000 cycles
  initial begin
    #400us;
    fails++;
    $display("mismatch t=%0t watchdog expired", $time);
    test_done();
  end

endmodule : tb_top
`default_nettype wire
